// ---- src/vr_cfg_consts.svh ----
`ifndef VR_CFG_CONSTS_SVH
`define VR_CFG_CONSTS_SVH

// register offsets
`define OFS_VER_UPPER 8'h71
`define OFS_RSV_72 8'h72
`define OFS_RSV_73 8'h73
`define OFS_PRODUCT_ID 8'h74
`define OFS_RSV_7A 8'h7a
`define OFS_RSV_7B 8'h7b
`define OFS_RSV_7C 8'h7c
`define OFS_RSV_7D 8'h7d
`define OFS_CHECKSUM 8'h7e
`define OFS_GAIN_FIRST 8'h90
`define OFS_GAIN_SECOND 8'h91

// reset values
`define RST_VER_UPPER 8'h00
`define RST_RSV_72 8'h01
`define RST_RSV_73 8'h34
`define RST_RSV_7A 8'h03
`define RST_RSV_7B 8'h40
`define RST_RSV_7C 8'h00
`define RST_RSV_7D 8'h01
`define RST_GAIN_FIRST 8'h92
`define RST_PH3_LOWER 1'h0

// gain field positions
`define PH1_HI 7
`define PH1_LO 5
`define PH2_HI 4
`define PH2_LO 2
`define PH3_UP_HI 1
`define PH3_UP_LO 0
`define PH3_LOW_BIT 7

// checksum code
`define CRC_POLY 8'h07
`define CRC_INIT 8'h00

// serial link
`define BITS_PER_BYTE 4'h8

`endif

// ---- src/vr_cfg_pkg.sv ----
package vr_cfg_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_PTR,
		ST_WR,
		ST_ACK,
		ST_TX,
		ST_TXACK
	} link_state_t;

	typedef struct packed {
		link_state_t st;
		link_state_t after_ack;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic [7:0] ptr;
		logic drive;
		logic scl_q;
		logic sda_q;
		logic [7:0] ver_upper;
		logic [7:0] rsv_72;
		logic [7:0] rsv_73;
		logic [7:0] product_id;
		logic [7:0] rsv_7a;
		logic [7:0] rsv_7b;
		logic [7:0] rsv_7c;
		logic [7:0] rsv_7d;
		logic [7:0] gain_first;
		logic ph3_lower;
		logic [7:0] crc;
	} cfg_state_t;

	typedef struct packed {
		logic [2:0] phase_one;
		logic [2:0] phase_two;
		logic [2:0] phase_three;
	} rail_a_gain_t;

endpackage : vr_cfg_pkg

// ---- src/vr_config_page_registers.sv ----
// Behaviour
// - checksum byte at 0x7E is a CRC of set-page contents; writes ignored
// - read-write byte at 0x71 holds upper firmware version bits of set page
// - phase-one gain of rail A in 0x90 bits 7:5, default code 100
// - phase-two gain of rail A in 0x90 bits 4:2, same coding
// - phase-three gain is 0x90 bits 1:0 joined with 0x91 bit 7 below
`timescale 1ns/1ps
`include "vr_cfg_consts.svh"

module vr_config_page_registers #(
	parameter logic [6:0] DEV_ADDR = 7'h2a,
	// arbitrary value, identifies nothing
	parameter logic [7:0] PRODUCT_ID_RST = 8'h5a
) (
	input wire logic core_clk, // system clock, 10 MHz
	input wire logic rst_n, // asynchronous reset, active low
	input wire logic scl_in, // serial clock from host
	input wire logic sda_in, // serial data level on the wire
	output logic sda_out, // serial data drive level, always low
	output logic sda_oe, // high while pulling serial data low
	output vr_cfg_pkg::rail_a_gain_t rail_a_gain, // gain codes to the loop
	output logic [7:0] set_page_version_upper_bits, // version upper byte
	output logic [7:0] product_identifier_code // product id byte
);

	logic rst_meta_ff;
	logic rst_sync_ff;
	vr_cfg_pkg::cfg_state_t s_ff;
	vr_cfg_pkg::cfg_state_t nxt_s;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	logic [7:0] rd_data;
	logic [7:0] crc_calc;
	logic wr_hit;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	function automatic logic [7:0] crc_byte(input logic [7:0] c,
		input logic [7:0] d);
		logic [7:0] r;
		r = c ^ d;
		for (int i = 0; i < 8; i++) begin
			r = r[7] ? ((r << 1) ^ `CRC_POLY) : (r << 1);
		end
		return r;
	endfunction : crc_byte

	// only the set-page bytes held here feed the code, in address order
	always_comb begin
		crc_calc = `CRC_INIT;
		crc_calc = crc_byte(crc_calc, s_ff.ver_upper);
		crc_calc = crc_byte(crc_calc, s_ff.rsv_72);
		crc_calc = crc_byte(crc_calc, s_ff.rsv_73);
		crc_calc = crc_byte(crc_calc, s_ff.product_id);
		crc_calc = crc_byte(crc_calc, s_ff.rsv_7a);
		crc_calc = crc_byte(crc_calc, s_ff.rsv_7b);
		crc_calc = crc_byte(crc_calc, s_ff.rsv_7c);
		crc_calc = crc_byte(crc_calc, s_ff.rsv_7d);
	end

	assign scl_rise = scl_in & ~s_ff.scl_q;
	assign scl_fall = ~scl_in & s_ff.scl_q;
	assign start_cond = scl_in & s_ff.scl_q & s_ff.sda_q & ~sda_in;
	assign stop_cond = scl_in & s_ff.scl_q & ~s_ff.sda_q & sda_in;
	assign wr_hit = (s_ff.st == vr_cfg_pkg::ST_WR) & scl_fall
		& (s_ff.cnt == `BITS_PER_BYTE);

	always_comb begin
		case (s_ff.ptr)
			`OFS_VER_UPPER: rd_data = s_ff.ver_upper;
			`OFS_RSV_72: rd_data = s_ff.rsv_72;
			`OFS_RSV_73: rd_data = s_ff.rsv_73;
			`OFS_PRODUCT_ID: rd_data = s_ff.product_id;
			`OFS_RSV_7A: rd_data = s_ff.rsv_7a;
			`OFS_RSV_7B: rd_data = s_ff.rsv_7b;
			`OFS_RSV_7C: rd_data = s_ff.rsv_7c;
			`OFS_RSV_7D: rd_data = s_ff.rsv_7d;
			`OFS_CHECKSUM: rd_data = s_ff.crc;
			`OFS_GAIN_FIRST: rd_data = s_ff.gain_first;
			`OFS_GAIN_SECOND: rd_data = {s_ff.ph3_lower, 7'h00};
			default: rd_data = 8'h00;
		endcase
	end

	always_comb begin
		nxt_s = s_ff;
		nxt_s.scl_q = scl_in;
		nxt_s.sda_q = sda_in;
		// follows every change of the held bytes, one cycle late
		nxt_s.crc = crc_calc;
		if (wr_hit) begin
			nxt_s.ptr = s_ff.ptr + 8'h01;
			nxt_s.st = vr_cfg_pkg::ST_ACK;
			nxt_s.after_ack = vr_cfg_pkg::ST_WR;
			nxt_s.drive = 1'b1;
			// reserved bytes keep whatever the host writes; holding their
			// fixed values is the host's duty
			case (s_ff.ptr)
				`OFS_VER_UPPER: nxt_s.ver_upper = s_ff.sh;
				`OFS_RSV_72: nxt_s.rsv_72 = s_ff.sh;
				`OFS_RSV_73: nxt_s.rsv_73 = s_ff.sh;
				`OFS_PRODUCT_ID: nxt_s.product_id = s_ff.sh;
				`OFS_RSV_7A: nxt_s.rsv_7a = s_ff.sh;
				`OFS_RSV_7B: nxt_s.rsv_7b = s_ff.sh;
				`OFS_RSV_7C: nxt_s.rsv_7c = s_ff.sh;
				`OFS_RSV_7D: nxt_s.rsv_7d = s_ff.sh;
				`OFS_GAIN_FIRST: nxt_s.gain_first = s_ff.sh;
				`OFS_GAIN_SECOND: nxt_s.ph3_lower = s_ff.sh[7];
				default: nxt_s.ptr = s_ff.ptr + 8'h01;
			endcase
		end else begin
			case (s_ff.st)
				vr_cfg_pkg::ST_IDLE: begin
					nxt_s.drive = 1'b0;
				end
				vr_cfg_pkg::ST_ADDR, vr_cfg_pkg::ST_PTR,
				vr_cfg_pkg::ST_WR: begin
					if (scl_rise) begin
						nxt_s.sh = {s_ff.sh[6:0], sda_in};
						nxt_s.cnt = s_ff.cnt + 4'h1;
					end else if (scl_fall && s_ff.cnt == `BITS_PER_BYTE) begin
						nxt_s.cnt = 4'h0;
						nxt_s.st = vr_cfg_pkg::ST_ACK;
						nxt_s.drive = 1'b1;
						if (s_ff.st == vr_cfg_pkg::ST_PTR) begin
							nxt_s.ptr = s_ff.sh;
							nxt_s.after_ack = vr_cfg_pkg::ST_WR;
						end else if (s_ff.sh[7:1] != DEV_ADDR) begin
							// not ours: stay off the wire until next start
							nxt_s.st = vr_cfg_pkg::ST_IDLE;
							nxt_s.drive = 1'b0;
						end else if (s_ff.sh[0]) begin
							nxt_s.after_ack = vr_cfg_pkg::ST_TX;
						end else begin
							nxt_s.after_ack = vr_cfg_pkg::ST_PTR;
						end
					end
				end
				vr_cfg_pkg::ST_ACK: begin
					nxt_s.cnt = 4'h0;
					if (scl_fall) begin
						nxt_s.st = s_ff.after_ack;
						nxt_s.drive = 1'b0;
						if (s_ff.after_ack == vr_cfg_pkg::ST_TX) begin
							nxt_s.sh = rd_data;
							nxt_s.ptr = s_ff.ptr + 8'h01;
							nxt_s.drive = ~rd_data[7];
						end
					end
				end
				vr_cfg_pkg::ST_TX: begin
					if (scl_rise) begin
						nxt_s.cnt = s_ff.cnt + 4'h1;
					end else if (scl_fall) begin
						if (s_ff.cnt == `BITS_PER_BYTE) begin
							nxt_s.st = vr_cfg_pkg::ST_TXACK;
							nxt_s.drive = 1'b0;
							nxt_s.cnt = 4'h0;
						end else begin
							nxt_s.sh = {s_ff.sh[6:0], 1'b0};
							nxt_s.drive = ~s_ff.sh[6];
						end
					end
				end
				vr_cfg_pkg::ST_TXACK: begin
					// host ack low: next byte; high: read ends
					if (scl_rise) begin
						nxt_s.cnt = {3'h0, ~sda_in};
					end else if (scl_fall) begin
						nxt_s.cnt = 4'h0;
						if (s_ff.cnt[0]) begin
							nxt_s.st = vr_cfg_pkg::ST_TX;
							nxt_s.sh = rd_data;
							nxt_s.ptr = s_ff.ptr + 8'h01;
							nxt_s.drive = ~rd_data[7];
						end else begin
							nxt_s.st = vr_cfg_pkg::ST_IDLE;
						end
					end
				end
				default: begin
					nxt_s.st = vr_cfg_pkg::ST_IDLE;
					nxt_s.drive = 1'b0;
				end
			endcase
		end
		// start and stop override any byte in flight
		if (start_cond) begin
			nxt_s.st = vr_cfg_pkg::ST_ADDR;
			nxt_s.cnt = 4'h0;
			nxt_s.drive = 1'b0;
		end else if (stop_cond) begin
			nxt_s.st = vr_cfg_pkg::ST_IDLE;
			nxt_s.cnt = 4'h0;
			nxt_s.drive = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			s_ff <= '0;
			s_ff.st <= vr_cfg_pkg::ST_IDLE;
			s_ff.after_ack <= vr_cfg_pkg::ST_IDLE;
			s_ff.scl_q <= 1'b1;
			s_ff.sda_q <= 1'b1;
			s_ff.ver_upper <= `RST_VER_UPPER;
			s_ff.rsv_72 <= `RST_RSV_72;
			s_ff.rsv_73 <= `RST_RSV_73;
			s_ff.product_id <= PRODUCT_ID_RST;
			s_ff.rsv_7a <= `RST_RSV_7A;
			s_ff.rsv_7b <= `RST_RSV_7B;
			s_ff.rsv_7c <= `RST_RSV_7C;
			s_ff.rsv_7d <= `RST_RSV_7D;
			s_ff.gain_first <= `RST_GAIN_FIRST;
			s_ff.ph3_lower <= `RST_PH3_LOWER;
			s_ff.crc <= `CRC_INIT;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe = s_ff.drive;
	assign rail_a_gain.phase_one =
		s_ff.gain_first[`PH1_HI:`PH1_LO];
	assign rail_a_gain.phase_two =
		s_ff.gain_first[`PH2_HI:`PH2_LO];
	assign rail_a_gain.phase_three =
		{s_ff.gain_first[`PH3_UP_HI:`PH3_UP_LO], s_ff.ph3_lower};
	assign set_page_version_upper_bits = s_ff.ver_upper;
	assign product_identifier_code = s_ff.product_id;

	// a byte load shows as the first cycle in the transmit state; the
	// pointer has already stepped on by then, so look one cycle back
	checksum_read_a: assert property (
		@(posedge core_clk) disable iff (!rst_sync_ff)
		$rose(s_ff.st == vr_cfg_pkg::ST_TX)
		&& $past(s_ff.ptr) == `OFS_CHECKSUM
		|-> s_ff.sh == $past(s_ff.crc))
		else $error("checksum read returned wrong byte");

	checksum_ro_a: assert property (
		@(posedge core_clk) disable iff (!rst_sync_ff)
		wr_hit && s_ff.ptr == `OFS_CHECKSUM
		|=> ##1 s_ff.crc == $past(s_ff.crc, 2))
		else $error("write to checksum changed it");

	version_write_a: assert property (
		@(posedge core_clk) disable iff (!rst_sync_ff)
		wr_hit && s_ff.ptr == `OFS_VER_UPPER
		|=> set_page_version_upper_bits == $past(s_ff.sh)
		##1 s_ff.crc == $past(crc_calc))
		else $error("version byte write lost");

	phase_one_a: assert property (
		@(posedge core_clk) disable iff (!rst_sync_ff)
		wr_hit && s_ff.ptr == `OFS_GAIN_FIRST
		|=> rail_a_gain.phase_one == $past(s_ff.sh[7:5]))
		else $error("phase one gain not from bits 7:5");

	phase_two_a: assert property (
		@(posedge core_clk) disable iff (!rst_sync_ff)
		wr_hit && s_ff.ptr == `OFS_GAIN_FIRST
		|=> rail_a_gain.phase_two == $past(s_ff.sh[4:2]))
		else $error("phase two gain not from bits 4:2");

	phase_three_a: assert property (
		@(posedge core_clk) disable iff (!rst_sync_ff)
		wr_hit && s_ff.ptr == `OFS_GAIN_SECOND
		|=> rail_a_gain.phase_three
			== {$past(s_ff.gain_first[1:0]), $past(s_ff.sh[7])})
		else $error("phase three gain joined wrongly");

	gain_hold_a: assert property (
		@(posedge core_clk) disable iff (!rst_sync_ff)
		!wr_hit |=> $stable(rail_a_gain))
		else $error("gain changed without a write");

	addr_ack_a: assert property (
		@(posedge core_clk) disable iff (!rst_sync_ff)
		s_ff.st == vr_cfg_pkg::ST_ADDR && scl_fall
		&& s_ff.cnt == `BITS_PER_BYTE && s_ff.sh[7:1] == DEV_ADDR
		&& !start_cond && !stop_cond |=> sda_oe)
		else $error("own address not acknowledged");

	gain_write_c: cover property (@(posedge core_clk)
		wr_hit && s_ff.ptr == `OFS_GAIN_SECOND);
	checksum_read_c: cover property (@(posedge core_clk)
		$rose(s_ff.st == vr_cfg_pkg::ST_TX)
		&& $past(s_ff.ptr) == `OFS_CHECKSUM);
	read_more_c: cover property (@(posedge core_clk)
		s_ff.st == vr_cfg_pkg::ST_TXACK && scl_fall && s_ff.cnt[0]);
	read_end_c: cover property (@(posedge core_clk)
		s_ff.st == vr_cfg_pkg::ST_TXACK && scl_fall && !s_ff.cnt[0]);

endmodule : vr_config_page_registers

// ---- tb/serial_host.sv ----
`timescale 1ns/1ps
module serial_host #(
	parameter logic [6:0] DEV_ADDR = 7'h2a
) (
	input wire logic core_clk, // system clock
	input wire logic sda, // resolved data wire
	output logic scl, // serial clock to device
	output logic sda_low // high while host pulls data low
);
	logic nak = 1'b0;
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// 4 cycles a level keeps above the 1-cycle minimum the device samples
	task automatic step(input logic c, input logic l);
		repeat (4) @(negedge core_clk);
		scl = c;
		sda_low = l;
	endtask : step
	task automatic bit_io(input logic d, output logic q);
		step(1'b0, !d);
		step(1'b1, !d);
		q = sda;
		step(1'b0, !d);
	endtask : bit_io
	task automatic frame_start;
		step(1'b0, 1'b0);
		step(1'b1, 1'b0);
		step(1'b1, 1'b1);
		step(1'b0, 1'b1);
	endtask : frame_start
	task automatic frame_stop;
		step(1'b0, 1'b1);
		step(1'b1, 1'b1);
		step(1'b1, 1'b0);
	endtask : frame_stop
	task automatic xfer(input logic [7:0] tx, input logic last,
		input logic chk, output logic [7:0] rx);
		logic a;
		for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
		bit_io(last, a);
		if (chk && a) nak = 1'b1;
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		frame_start;
		xfer({DEV_ADDR, 1'b0}, 1'b1, 1'b1, r);
		xfer(a, 1'b1, 1'b1, r);
		xfer(d, 1'b1, 1'b1, r);
		frame_stop;
	endtask : wr
	// single-byte read ends with a nack so the device lets go of the line
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		logic [7:0] r;
		frame_start;
		xfer({DEV_ADDR, 1'b0}, 1'b1, 1'b1, r);
		xfer(a, 1'b1, 1'b1, r);
		frame_start;
		xfer({DEV_ADDR, 1'b1}, 1'b1, 1'b1, r);
		xfer(8'hff, 1'b1, 1'b0, d);
		frame_stop;
	endtask : rd
	// two-byte read: host acks the first byte so the pointer steps on
	task automatic rd2(input logic [7:0] a, output logic [7:0] d0,
		output logic [7:0] d1);
		logic [7:0] r;
		frame_start;
		xfer({DEV_ADDR, 1'b0}, 1'b1, 1'b1, r);
		xfer(a, 1'b1, 1'b1, r);
		frame_start;
		xfer({DEV_ADDR, 1'b1}, 1'b1, 1'b1, r);
		xfer(8'hff, 1'b0, 1'b0, d0);
		xfer(8'hff, 1'b1, 1'b0, d1);
		frame_stop;
	endtask : rd2
endmodule : serial_host

// ---- tb/vr_config_page_registers_test.sv ----
`timescale 1ns/1ps
module vr_config_page_registers_test;
	localparam logic [7:0] PID = 8'h3c; // arbitrary value
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic scl, sda_low, sda, sda_out, sda_oe;
	vr_cfg_pkg::rail_a_gain_t gain;
	logic [7:0] ver, pid;
	int errors = 0;
	int tests_run = 0;
	logic [15:0] seed = 16'h706f;
	logic [7:0] adr [8] = '{8'h71, 8'h72, 8'h73, 8'h74, 8'h7a, 8'h7b,
		8'h7c, 8'h7d};
	logic [7:0] pg [8] = '{8'h00, 8'h01, 8'h34, PID, 8'h03, 8'h40, 8'h00,
		8'h01};
	// pull-up wins unless someone drives low
	assign sda = !sda_low & (!sda_oe | sda_out);
	always #50 core_clk = !core_clk;
	vr_config_page_registers #(.PRODUCT_ID_RST(PID))
		vr_config_page_registers_inst (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.scl_in(scl),
		.sda_in(sda),
		.sda_out(sda_out),
		.sda_oe(sda_oe),
		.rail_a_gain(gain),
		.set_page_version_upper_bits(ver),
		.product_identifier_code(pid)
	);
	serial_host serial_host_inst (
		.core_clk(core_clk),
		.sda(sda),
		.scl(scl),
		.sda_low(sda_low)
	);
	function automatic logic [7:0] nxt();
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		return seed[7:0];
	endfunction : nxt
	function automatic logic [7:0] crc_of();
		logic [7:0] c = 8'h00;
		for (int i = 0; i < 8; i++) begin
			c ^= pg[i];
			repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
		end
		return c;
	endfunction : crc_of
	task automatic check(input string what, input logic [8:0] seen,
		input logic [8:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic end_sim;
		$display("checks %0d errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : end_sim
	// a full run needs about 17k cycles
	initial begin
		repeat (40000) @(posedge core_clk);
		errors++;
		end_sim;
	end
	initial begin
		logic [7:0] r;
		logic [7:0] v;
		repeat (5) @(negedge core_clk);
		rst_n = 1'b1;
		repeat (4) @(negedge core_clk);
		check("gain out", gain, 9'h124);
		check("version out", ver, 8'h00);
		check("id out", pid, PID);
		for (int i = 0; i < 8; i++) begin
			serial_host_inst.rd(adr[i], r);
			check("reset value", r, pg[i]);
		end
		serial_host_inst.rd(8'h90, r);
		check("gain reg", r, 8'h92);
		serial_host_inst.rd(8'h7e, r);
		check("checksum", r, crc_of());
		serial_host_inst.wr(8'h7e, ~r);
		serial_host_inst.rd(8'h7e, v);
		check("checksum kept", v, r);
		serial_host_inst.wr(8'h73, 8'h34);
		v = {nxt() & 8'hf8} | 8'h03;
		serial_host_inst.wr(8'h7a, v);
		pg[4] = v;
		serial_host_inst.wr(8'h7b, 8'h40);
		for (int c = 0; c < 8; c++) begin
			v = 8'(7 - c);
			serial_host_inst.wr(8'h90, {c[2:0], v[2:0], c[2:1]});
			serial_host_inst.wr(8'h91, {c[0], 7'h00});
			check("gain code", gain, {c[2:0], v[2:0], c[2:0]});
		end
		for (int k = 0; k < 4; k++) begin
			v = nxt();
			serial_host_inst.wr(8'h71, v);
			pg[0] = v;
			check("version out", ver, v);
			serial_host_inst.rd(8'h7e, r);
			check("checksum upd", r, crc_of());
		end
		// last gain pass left 0x90 = 111_000_11 and 0x91 bit 7 set
		serial_host_inst.rd2(8'h90, r, v);
		check("gain reg last", r, 8'he3);
		check("gain lsb reg", v, 8'h80);
		serial_host_inst.rd(8'h75, r);
		check("unmapped", r, 8'h00);
		// second reset with the link idle must restore the defaults
		@(negedge core_clk);
		rst_n = 1'b0;
		repeat (2) @(negedge core_clk);
		rst_n = 1'b1;
		repeat (4) @(negedge core_clk);
		check("gain rst", gain, 9'h124);
		check("version rst", ver, 8'h00);
		serial_host_inst.rd(8'h91, r);
		check("gain lsb rst", r, 8'h00);
		check("ack", serial_host_inst.nak, 1'b0);
		end_sim;
	end
endmodule : vr_config_page_registers_test
